// >>> logic/dbt_trace.sv
// Bus comparators, trigger logic and 8-stage capture FIFO.
// Assumes CPU bus signals are synchronous to mclk; Avalon-MM slave.
module dbt_trace (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [15:0] cpu_addr,
  input wire logic [7:0] cpu_rdata,
  input wire logic [7:0] cpu_wdata,
  input wire logic cpu_rw,
  input wire logic cpu_valid,
  input wire logic bdc_access,
  input wire logic op_fetch,
  input wire logic op_exec,
  input wire logic [15:0] exec_addr,
  input wire logic cof_valid,
  input wire dbt_pkg::dbt_cof_t cof_kind,
  input wire logic [15:0] cof_src,
  input wire logic [15:0] cof_dst,
  output logic brk_tag,
  output logic brk_force
);
  import dbt_pkg::*;

  function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
    return a[4:2] == off[4:2];
  endfunction

  logic [15:0] cmp_a;
  logic [15:0] cmp_b;
  logic [7:0] ctrl;
  logic [7:0] trig;
  logic [15:0] fifo [FIFO_DEPTH];
  logic [3:0] fifo_valid_count;
  logic flag_a;
  logic flag_b;
  logic a_seen;
  logic [1:0] skip_cnt;
  logic [15:0] last_fetch;
  dbt_run_t run;
  logic [1:0] trk;

  // ****************************************
  // Bus slave
  // ****************************************
  logic acc;
  logic wr_ctrl;
  logic pop;
  logic armed_flag;
  assign acc = (avs_read | avs_write) & ~avs_waitrequest;
  assign wr_ctrl = acc & avs_write & hit(avs_address, CTRL_ADDR) & avs_byteenable[0];
  assign pop = acc & avs_read & hit(avs_address, FLO_ADDR);
  assign armed_flag = run != DBT_OFF;

  // One wait cycle: read data is built at the first edge of the request
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      avs_waitrequest <= 1'b1;
    else
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      avs_readdata <= 32'h0000_0000;
    else if (avs_read & avs_waitrequest)
    begin
      avs_readdata <= 32'h0000_0000;
      if (hit(avs_address, CMPA_ADDR))
        avs_readdata[15:0] <= cmp_a;
      if (hit(avs_address, CMPB_ADDR))
        avs_readdata[15:0] <= cmp_b;
      if (hit(avs_address, CTRL_ADDR))
        avs_readdata[7:0] <= ctrl;
      if (hit(avs_address, TRIG_ADDR))
        avs_readdata[7:0] <= trig;
      if (hit(avs_address, STAT_ADDR))
        avs_readdata[7:0] <= {flag_a, flag_b, armed_flag, 1'b0, fifo_valid_count};
      if (hit(avs_address, FHI_ADDR))
        avs_readdata[7:0] <= fifo[0][15:8];
      if (hit(avs_address, FLO_ADDR))
        avs_readdata[7:0] <= fifo[0][7:0];
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cmp_a <= CMP_RST;
      cmp_b <= CMP_RST;
      trig <= TRIG_RST;
    end
    else if (acc & avs_write)
    begin
      if (hit(avs_address, CMPA_ADDR) & avs_byteenable[0])
        cmp_a[7:0] <= avs_writedata[7:0];
      if (hit(avs_address, CMPA_ADDR) & avs_byteenable[1])
        cmp_a[15:8] <= avs_writedata[15:8];
      if (hit(avs_address, CMPB_ADDR) & avs_byteenable[0])
        cmp_b[7:0] <= avs_writedata[7:0];
      if (hit(avs_address, CMPB_ADDR) & avs_byteenable[1])
        cmp_b[15:8] <= avs_writedata[15:8];
      if (hit(avs_address, TRIG_ADDR) & avs_byteenable[0])
        trig <= avs_writedata[7:0];
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      ctrl <= CTRL_RST;
    else if (wr_ctrl)
      ctrl <= avs_writedata[7:0];
  end

  // ****************************************
  // Comparators
  // ****************************************
  dbt_mode_t mode;
  logic bus_ok;
  logic [7:0] data_b;
  logic data_eq;
  logic [1:0] raw;
  logic [1:0] q;
  logic sel;
  logic event_mode;
  logic begin_mode;
  assign mode = dbt_mode_t'(trig[3:0]);
  assign sel = trig[TRG_SEL];
  assign bus_ok = cpu_valid & ~bdc_access;
  assign data_b = (ctrl[CTL_RW_QUAL_ENABLE_A] & ~ctrl[CTL_RWA]) ? cpu_wdata : cpu_rdata;
  assign data_eq = data_b == cmp_b[7:0];
  assign event_mode = (mode == DBT_EV_B) | (mode == DBT_A_THEN_EV_B);
  assign begin_mode = trig[TRG_BEGIN] | event_mode;

  always_comb
  begin
    raw[0] = bus_ok & (~ctrl[CTL_RW_QUAL_ENABLE_A] | (cpu_rw == ctrl[CTL_RWA]));
    raw[1] = bus_ok & (~ctrl[CTL_RWBEN] | (cpu_rw == ctrl[CTL_RWB])) & (cpu_addr == cmp_b);
    if (mode == DBT_INSIDE)
      raw[0] = raw[0] & (cpu_addr >= cmp_a) & (cpu_addr <= cmp_b);
    else if (mode == DBT_OUTSIDE)
      raw[0] = raw[0] & ((cpu_addr < cmp_a) | (cpu_addr > cmp_b));
    else
      raw[0] = raw[0] & (cpu_addr == cmp_a);
  end

  // Opcode trackers, one per comparator, so both can be in flight
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : gen_trk
      logic [15:0] addr_q;
      logic live_q;
      assign trk[g] = live_q & op_exec & (exec_addr == addr_q);
      always_ff @(posedge mclk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          addr_q <= 16'h0000;
          live_q <= 1'b0;
        end
        else if (op_fetch & raw[g])
        begin
          addr_q <= cpu_addr;
          live_q <= 1'b1;
        end
        else if (trk[g])
          live_q <= 1'b0;
      end
    end
  endgenerate

  assign q = sel ? trk : raw;

  // ****************************************
  // Trigger decode
  // ****************************************
  logic trig_hit;
  logic tag_hit;
  always_comb
  begin
    trig_hit = 1'b0;
    tag_hit = raw[0];
    unique case (mode)
      DBT_A_ONLY: trig_hit = q[0];
      DBT_A_OR_B:
      begin
        trig_hit = q[0] | q[1];
        tag_hit = raw[0] | raw[1];
      end
      DBT_A_THEN_B, DBT_A_THEN_EV_B:
      begin
        trig_hit = a_seen & q[1];
        tag_hit = a_seen & raw[1];
      end
      DBT_EV_B:
      begin
        trig_hit = q[1];
        tag_hit = raw[1];
      end
      // Tracked opcodes carry no data, so data is only checked untracked
      DBT_A_AND_D: trig_hit = q[0] & (sel | data_eq);
      DBT_A_NOT_D: trig_hit = q[0] & (sel | ~data_eq);
      DBT_INSIDE, DBT_OUTSIDE: trig_hit = q[0];
      default: trig_hit = 1'b0;
    endcase
  end

  // ****************************************
  // Run control and breakpoints
  // ****************************************
  logic start;
  logic halt;
  logic cof_ok;
  logic [15:0] cof_word;
  logic push_run;
  logic push;
  logic [15:0] push_word;
  logic end_trig;
  assign start = wr_ctrl & avs_writedata[CTL_ARM] & avs_writedata[CTL_EN];
  assign halt = wr_ctrl & ~start & armed_flag;
  assign cof_ok = cof_valid & (cof_kind != DBT_COF_NONE);
  assign cof_word = (cof_kind == DBT_COF_BRANCH) ? cof_src : cof_dst;
  assign end_trig = (run == DBT_STORE) & ~begin_mode & trig_hit;

  always_comb
  begin
    push_run = 1'b0;
    push_word = {8'h00, cpu_rw ? cpu_rdata : cpu_wdata};
    if (run == DBT_WAIT & event_mode)
      push_run = trig_hit;
    else if (run == DBT_STORE)
    begin
      push_run = cof_ok & (skip_cnt == 2'h0);
      push_word = cof_word;
    end
    else if (~ctrl[CTL_ARM])
      push_word = last_fetch;
  end
  assign push = push_run | (pop & ~ctrl[CTL_ARM] & ~armed_flag);

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      run <= DBT_OFF;
    else if (start)
      run <= begin_mode ? DBT_WAIT : DBT_STORE;
    else if (halt)
      run <= DBT_OFF;
    else if (end_trig)
      run <= DBT_OFF;
    else if (run == DBT_WAIT & ~event_mode & trig_hit)
      run <= DBT_STORE;
    else if (push_run & fifo_valid_count == CNT_FULL - 4'h1)
      run <= DBT_OFF;
  end

  // Trigger cycle is skipped by state; two more bus cycles by count
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      skip_cnt <= 2'h0;
    // A cut begin run must not mask flow entries of the next run
    else if (start)
      skip_cnt <= 2'h0;
    else if (run == DBT_WAIT & ~event_mode & trig_hit)
      skip_cnt <= COF_SKIP;
    else if (cpu_valid & skip_cnt != 2'h0)
      skip_cnt <= skip_cnt - 2'h1;
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      flag_a <= 1'b0;
      flag_b <= 1'b0;
      a_seen <= 1'b0;
    end
    else if (start)
    begin
      flag_a <= 1'b0;
      flag_b <= 1'b0;
      a_seen <= 1'b0;
    end
    else if (armed_flag)
    begin
      flag_a <= flag_a | q[0];
      flag_b <= flag_b | q[1];
      a_seen <= a_seen | q[0];
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      last_fetch <= 16'h0000;
    else if (op_fetch)
      last_fetch <= cpu_addr;
  end

  // Requests are one-cycle pulses; the CPU holds its own pending state
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      brk_tag <= 1'b0;
      brk_force <= 1'b0;
    end
    else
    begin
      brk_tag <= armed_flag & ctrl[CTL_EN] & ctrl[CTL_BRK] & ctrl[CTL_TAG] & op_fetch & tag_hit;
      brk_force <= armed_flag & ctrl[CTL_EN] & ctrl[CTL_BRK] & ~ctrl[CTL_TAG] & trig_hit;
    end
  end

  // ****************************************
  // Capture FIFO
  // ****************************************
  logic shift;
  assign shift = push | pop | (halt & fifo_valid_count != CNT_FULL);

  // Newest enters the top stage; the port sees stage zero, oldest first
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < FIFO_DEPTH; i++)
        fifo[i] <= 16'h0000;
    end
    else if (shift)
    begin
      for (int i = 0; i < FIFO_DEPTH - 1; i++)
        fifo[i] <= fifo[i + 1];
      fifo[FIFO_DEPTH - 1] <= push ? push_word : 16'h0000;
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      fifo_valid_count <= 4'h0;
    else if (start)
      fifo_valid_count <= 4'h0;
    else if (push & ~(pop & ctrl[CTL_ARM]))
    begin
      if (fifo_valid_count != CNT_FULL)
        fifo_valid_count <= fifo_valid_count + 4'h1;
    end
    else if (pop & ~push & fifo_valid_count != 4'h0)
      fifo_valid_count <= fifo_valid_count - 4'h1;
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  bdc_quiet_a: assert property (bdc_access & ~sel |-> ~trig_hit & ~push_run)
    else $error("match during debug link access");
  force_brk_a: assert property (armed_flag & ctrl[CTL_EN] & ctrl[CTL_BRK] & ~ctrl[CTL_TAG] & trig_hit
    |=> brk_force)
    else $error("force break missing");
  count_full_a: assert property (push & ~pop & fifo_valid_count == 4'h7 & ~start
    |=> fifo_valid_count == CNT_FULL ##1 fifo_valid_count <= CNT_FULL)
    else $error("count did not reach full");
  full_ends_a: assert property (push_run & ~start & ~halt & begin_mode & fifo_valid_count == 4'h7
    |=> run == DBT_OFF)
    else $error("begin trace did not end at full");
  fifo_order_a: assert property (push |=> fifo[FIFO_DEPTH - 1] == $past(push_word))
    else $error("stored word lost");
  pop_shift_a: assert property (pop |=> fifo[0] == $past(fifo[1]))
    else $error("low read did not advance");
  start_clear_a: assert property (start |=> fifo_valid_count == 4'h0 && !flag_a && !flag_b
    && armed_flag)
    else $error("arm did not start clean run");
  skip_cof_a: assert property (run == DBT_WAIT & ~event_mode & trig_hit & ~start & ~halt
    |=> ~push_run)
    else $error("flow stored too soon");
  profile_a: assert property (pop & ~ctrl[CTL_ARM] & ~armed_flag |=> fifo[FIFO_DEPTH - 1] == $past(last_fetch))
    else $error("profile address not pushed");
  halt_offset_a: assert property (halt & fifo_valid_count != CNT_FULL & ~push |=> fifo[0] == $past(fifo[1]))
    else $error("halt offset missing");
  end_store_a: assert property (end_trig & cof_ok & ~halt & ~start |=> run == DBT_OFF
    && fifo[FIFO_DEPTH - 1] == $past(cof_word))
    else $error("end trigger flow not stored");

  begin_run_c: cover property (run == DBT_WAIT ##1 run == DBT_STORE ##[1:200] run == DBT_OFF);
  event_full_c: cover property (event_mode & fifo_valid_count == CNT_FULL);
  tag_brk_c: cover property (brk_tag);
  profile_c: cover property (pop & ~ctrl[CTL_ARM] ##[1:50] pop);
endmodule

// >>> logic/dbt_pkg.sv
// Constants for the bus trace and trigger unit.
// Assumes one 20 MHz clock shared with the CPU core buses.
package dbt_pkg;
  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [4:0] CMPA_ADDR = 5'h00;
  localparam logic [4:0] CMPB_ADDR = 5'h04;
  localparam logic [4:0] CTRL_ADDR = 5'h08;
  localparam logic [4:0] TRIG_ADDR = 5'h0C;
  localparam logic [4:0] STAT_ADDR = 5'h10;
  localparam logic [4:0] FHI_ADDR = 5'h14;
  localparam logic [4:0] FLO_ADDR = 5'h18;
  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int CTL_EN = 7;
  localparam int CTL_ARM = 6;
  localparam int CTL_TAG = 5;
  localparam int CTL_BRK = 4;
  localparam int CTL_RW_QUAL_ENABLE_A = 3;
  localparam int CTL_RWA = 2;
  localparam int CTL_RWBEN = 1;
  localparam int CTL_RWB = 0;
  localparam int TRG_SEL = 7;
  localparam int TRG_BEGIN = 6;
  localparam int ST_AF = 7;
  localparam int ST_BF = 6;
  localparam int ST_ARMED_FLAG = 5;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] TRIG_RST = 8'h00;
  localparam logic [15:0] CMP_RST = 16'h0000;
  // ****************************************
  // Capture constants
  // ****************************************
  localparam int FIFO_DEPTH = 8;
  localparam logic [3:0] CNT_FULL = 4'h8;
  localparam logic [1:0] COF_SKIP = 2'h2;
  typedef enum logic [3:0] {
    DBT_A_ONLY, DBT_A_OR_B, DBT_A_THEN_B, DBT_EV_B, DBT_A_THEN_EV_B,
    DBT_A_AND_D, DBT_A_NOT_D, DBT_INSIDE, DBT_OUTSIDE
  } dbt_mode_t;
  typedef enum logic [1:0] {DBT_COF_BRANCH, DBT_COF_NONE, DBT_COF_DEST} dbt_cof_t;
  typedef enum logic [1:0] {DBT_OFF, DBT_WAIT, DBT_STORE} dbt_run_t;
endpackage

// >>> testbench/dbt_cpu_model.sv
// CPU core bus model facing the trace unit.
// Assumes the bench calls cyc once per bus cycle; each is followed by an idle cycle.
module dbt_cpu_model import dbt_pkg::*; (
  input wire logic mclk,
  output logic [15:0] cpu_addr,
  output logic [7:0] cpu_rdata,
  output logic [7:0] cpu_wdata,
  output logic cpu_rw,
  output logic cpu_valid,
  output logic bdc_access,
  output logic op_fetch,
  output logic op_exec,
  output logic [15:0] exec_addr,
  output logic cof_valid,
  output dbt_pkg::dbt_cof_t cof_kind,
  output logic [15:0] cof_src,
  output logic [15:0] cof_dst
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    {cpu_addr, cpu_rdata, cpu_wdata, cpu_rw, cpu_valid} = 34'h0;
    {bdc_access, op_fetch, op_exec, exec_addr, cof_valid} = 20'h0;
    {cof_src, cof_dst} = 32'h0;
    cof_kind = DBT_COF_NONE;
  end
  // Flags: bdc, fetch, exec, flow change
  task automatic cyc(input logic [15:0] a, input logic rw, input logic [7:0] d, input logic [3:0] fl,
                     input logic [1:0] ck, input logic [15:0] p);
    @(posedge mclk);
    cpu_addr <= a;
    cpu_rw <= rw;
    cpu_rdata <= rw ? d : ~d;
    cpu_wdata <= rw ? ~d : d;
    cpu_valid <= 1'b1;
    {bdc_access, op_fetch, op_exec, cof_valid} <= fl;
    exec_addr <= a;
    cof_kind <= dbt_cof_t'(ck);
    cof_src <= p;
    cof_dst <= ~p;
    @(posedge mclk);
    // Idle bus shows inverted address, data and flow words; exec_addr, cpu_rw and cof_kind keep theirs
    cpu_addr <= ~a;
    cpu_rdata <= rw ? ~d : d;
    cpu_wdata <= rw ? d : ~d;
    cpu_valid <= 1'b0;
    {bdc_access, op_fetch, op_exec, cof_valid} <= 4'h0;
    cof_src <= ~p;
    cof_dst <= p;
  endtask
endmodule

// >>> testbench/testbench.sv
// Self-checking bench for the trace and trigger unit.
// Assumes dbt_trace and the CPU model; registers reached over Avalon-MM.
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_total++; $display("unexpected at %0t: %0h vs %0h", $time, (g), (e)); end end
module testbench import dbt_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, arst_n, avs_read, avs_write, avs_waitrequest, brk_tag, brk_force;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  logic [15:0] cpu_addr, exec_addr, cof_src, cof_dst;
  logic [7:0] cpu_rdata, cpu_wdata;
  logic cpu_rw, cpu_valid, bdc_access, op_fetch, op_exec, cof_valid;
  dbt_cof_t cof_kind;
  int err_total, checks, nt, nf, i;
  logic [15:0] q[$];
  dbt_trace dbt_trace_i (.mclk(mclk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cpu_addr(cpu_addr), .cpu_rdata(cpu_rdata),
    .cpu_wdata(cpu_wdata), .cpu_rw(cpu_rw), .cpu_valid(cpu_valid), .bdc_access(bdc_access), .op_fetch(op_fetch),
    .op_exec(op_exec), .exec_addr(exec_addr), .cof_valid(cof_valid), .cof_kind(cof_kind), .cof_src(cof_src),
    .cof_dst(cof_dst), .brk_tag(brk_tag), .brk_force(brk_force));
  dbt_cpu_model dbt_cpu_model_i (.mclk(mclk), .cpu_addr(cpu_addr), .cpu_rdata(cpu_rdata), .cpu_wdata(cpu_wdata),
    .cpu_rw(cpu_rw), .cpu_valid(cpu_valid), .bdc_access(bdc_access), .op_fetch(op_fetch), .op_exec(op_exec),
    .exec_addr(exec_addr), .cof_valid(cof_valid), .cof_kind(cof_kind), .cof_src(cof_src), .cof_dst(cof_dst));
  // ****************************************
  // Tasks
  // ****************************************
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    if (brk_tag === 1'b1) nt++;
    if (brk_force === 1'b1) nf++;
  end
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Request held until waitrequest is sampled low
  task automatic av(input logic wr, input logic [4:0] a, input logic [15:0] wd, output logic [31:0] rd);
    int n;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= {16'h0000, wd};
    avs_write <= wr;
    avs_read <= ~wr;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 64);
    if (n >= 64)
    begin
      err_total++;
      finish_test();
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    logic [31:0] x;
    av(1'b1, a, d, x);
  endtask
  task automatic rdchk(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFFFFFF);
    logic [31:0] x;
    av(1'b0, a, 16'h0000, x);
    `CHK(x & m, e)
  endtask
  task automatic skip_read(input logic [4:0] a);
    logic [31:0] x;
    av(1'b0, a, 16'h0000, x);
  endtask
  task automatic fifo_word(input logic [15:0] e);
    rdchk(FHI_ADDR, {24'h0, e[15:8]});
    rdchk(FLO_ADDR, {24'h0, e[7:0]});
  endtask
  task automatic c(input logic [15:0] a, input logic rw, input logic [7:0] d, input logic [3:0] fl,
                   input logic [1:0] ck, input logic [15:0] p);
    dbt_cpu_model_i.cyc(a, rw, d, fl, ck, p);
  endtask
  // Arms a run, makes one bus cycle, counts break pulses
  task automatic brk(input logic [7:0] ctl, trg, input logic [15:0] a, input logic rw, input logic [7:0] d,
                     input logic [3:0] fl, input int et, ef);
    int t0, f0;
    wr(TRIG_ADDR, {8'h00, trg});
    wr(CTRL_ADDR, {8'h00, ctl});
    t0 = nt;
    f0 = nf;
    c(a, rw, d, fl, 2'd1, 16'h0000);
    repeat (2) @(posedge mclk);
    `CHK(nt - t0, et)
    `CHK(nf - f0, ef)
  endtask
  // Two bus cycles on an armed run, counts force pulses
  task automatic two(input logic [15:0] a1, a2, input logic [3:0] fl, input int ef);
    int f0;
    f0 = nf;
    c(a1, 1, 8'h00, fl, 2'd1, 16'h0000);
    c(a2, 1, 8'h00, fl, 2'd1, 16'h0000);
    repeat (2) @(posedge mclk);
    `CHK(nf - f0, ef)
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    {err_total, checks, nt, nf} = '0;
    {arst_n, avs_read, avs_write, avs_address, avs_writedata} = '0;
    avs_byteenable = 4'h3;
    repeat (5) @(posedge mclk);
    arst_n <= 1'b1;
    rdchk(CTRL_ADDR, 32'h0);
    rdchk(TRIG_ADDR, 32'h0);
    rdchk(STAT_ADDR, 32'h0);
    rdchk(CMPA_ADDR, 32'h0);
    wr(5'h1C, 16'hFFFF);
    rdchk(5'h1C, 32'h0);
    `CHK(nt + nf, 0)
    $display("test reset done");
    wr(CMPA_ADDR, 16'h1000);
    wr(CMPB_ADDR, 16'h10FF);
    rdchk(CMPB_ADDR, 32'h10FF);
    brk(8'hD0, 8'h00, 16'h1000, 1, 8'h00, 4'h0, 0, 1);
    brk(8'hD0, 8'h00, 16'h1000, 1, 8'h00, 4'h8, 0, 0);
    brk(8'hD8, 8'h00, 16'h1000, 1, 8'h00, 4'h0, 0, 0);
    brk(8'hD8, 8'h00, 16'h1000, 0, 8'h00, 4'h0, 0, 1);
    brk(8'hD0, 8'h01, 16'h10FF, 1, 8'h00, 4'h0, 0, 1);
    brk(8'hD0, 8'h07, 16'h0FFF, 1, 8'h00, 4'h0, 0, 0);
    brk(8'hD0, 8'h07, 16'h10FF, 1, 8'h00, 4'h0, 0, 1);
    brk(8'hD0, 8'h08, 16'h1100, 1, 8'h00, 4'h0, 0, 1);
    brk(8'hD0, 8'h08, 16'h1000, 1, 8'h00, 4'h0, 0, 0);
    brk(8'hD0, 8'h05, 16'h1000, 1, 8'hFF, 4'h0, 0, 1);
    brk(8'hD0, 8'h05, 16'h1000, 1, 8'h00, 4'h0, 0, 0);
    brk(8'hD8, 8'h05, 16'h1000, 0, 8'hFF, 4'h0, 0, 1);
    brk(8'hD0, 8'h06, 16'h1000, 1, 8'hFF, 4'h0, 0, 0);
    brk(8'hF0, 8'h00, 16'h1000, 1, 8'h00, 4'h4, 1, 0);
    brk(8'hF0, 8'h00, 16'h1004, 1, 8'h00, 4'h4, 0, 0);
    brk(8'hD0, 8'h80, 16'h1000, 1, 8'h00, 4'h4, 0, 0);
    two(16'h2000, 16'h1000, 4'h2, 1);
    brk(8'hD0, 8'h02, 16'h10FF, 1, 8'h00, 4'h0, 0, 0);
    two(16'h1000, 16'h10FF, 4'h0, 1);
    $display("test breaks done");
    wr(TRIG_ADDR, 16'h0040);
    wr(CTRL_ADDR, 16'h00C0);
    rdchk(STAT_ADDR, 32'h20, 32'h2F);
    c(16'h1000, 1, 8'h00, 4'h1, 2'd0, 16'h0A01);
    c(16'h0100, 1, 8'h00, 4'h1, 2'd2, 16'h0A02);
    c(16'h0102, 1, 8'h00, 4'h1, 2'd0, 16'h0A03);
    for (i = 0; i < 10; i++)
    begin
      c(16'h0200 + i[15:0], 1, 8'h00, 4'h1, (i == 4) ? 2'd1 : (i[0] ? 2'd2 : 2'd0), 16'hB000 + i[15:0]);
      if (i != 4 && q.size() < 8) q.push_back(i[0] ? ~(16'hB000 + i[15:0]) : 16'hB000 + i[15:0]);
    end
    rdchk(STAT_ADDR, 32'h08, 32'h2F);
    foreach (q[k]) fifo_word(q[k]);
    $display("test begin trace done");
    wr(TRIG_ADDR, 16'h0003);
    wr(CTRL_ADDR, 16'h00C0);
    c(16'h10FF, 1, 8'h5A, 4'h0, 2'd1, 16'h0000);
    c(16'h10FF, 0, 8'hA5, 4'h0, 2'd1, 16'h0000);
    c(16'h10FF, 1, 8'h77, 4'h8, 2'd1, 16'h0000);
    rdchk(STAT_ADDR, 32'h02, 32'h0F);
    wr(CTRL_ADDR, 16'h0080);
    repeat ((8 - 2) - 1) skip_read(FLO_ADDR);
    rdchk(FHI_ADDR, 32'h0);
    rdchk(FLO_ADDR, 32'h5A);
    rdchk(FLO_ADDR, 32'hA5);
    $display("test event done");
    wr(TRIG_ADDR, 16'h0040);
    wr(CTRL_ADDR, 16'h00C0);
    c(16'h1000, 1, 8'h00, 4'h0, 2'd1, 16'h0000);
    repeat (2) c(16'h0300, 1, 8'h00, 4'h0, 2'd1, 16'h0000);
    for (i = 0; i < 3; i++) c(16'h0310, 1, 8'h00, 4'h1, 2'd0, 16'hC000 + i[15:0]);
    wr(CTRL_ADDR, 16'h0080);
    rdchk(STAT_ADDR, 32'h03, 32'h2F);
    repeat ((8 - 3) - 1) skip_read(FLO_ADDR);
    for (i = 0; i < 3; i++) fifo_word(16'hC000 + i[15:0]);
    $display("test halt done");
    c(16'h3456, 1, 8'h00, 4'h4, 2'd1, 16'h0000);
    repeat (8) skip_read(FLO_ADDR);
    fifo_word(16'h3456);
    $display("test profile done");
    finish_test();
  end
endmodule
